// ### common/pcs_defines.vh
`ifndef PCS_DEFINES_VH
`define PCS_DEFINES_VH

// ----------------------------------------
// register addresses (internal sfr space)
// ----------------------------------------
`define PCS_ADDR_POL      8'hae
`define PCS_ADDR_CFG_LO   8'hc2
`define PCS_ADDR_CFG_HI   8'hc3
`define PCS_ADDR_DATA     8'hd8
`define PCS_ADDR_B0_LO    8'h84
`define PCS_ADDR_B0_HI    8'h85
`define PCS_ADDR_B1_LO    8'h94
`define PCS_ADDR_B1_HI    8'h95
`define PCS_ADDR_B2_LO    8'hac
`define PCS_ADDR_B2_HI    8'had
`define PCS_ADDR_B3_LO    8'hb4
`define PCS_ADDR_B3_HI    8'hb5

// ----------------------------------------
// reset values
// ----------------------------------------
`define PCS_RST_CFG       8'h00
`define PCS_RST_POL       4'h0
`define PCS_RST_BASE      8'h00
`define PCS_RST_DATA      4'hf

// ----------------------------------------
// field positions
// ----------------------------------------
`define PCS_ROLE_HI_POS   3'd6
`define PCS_CMP_HI_POS    3'd4
`define PCS_ROLE_LO_POS   3'd2
`define PCS_CMP_LO_POS    3'd0
`define PCS_POL_POS       3'd4
`define PCS_POL_RSVD      4'h0

// ----------------------------------------
// encodings
// ----------------------------------------
`define PCS_ROLE_IO       2'b00
`define PCS_ROLE_RD       2'b01
`define PCS_ROLE_WR       2'b10
`define PCS_ROLE_RW       2'b11
`define PCS_CMP_FULL      2'b00
`define PCS_CMP_A1        2'b01
`define PCS_CMP_A2        2'b10
`define PCS_CMP_A8        2'b11

`endif

// ### hw/pcs_pin_strobe.v
`timescale 1ns/100ps
`include "pcs_defines.vh"

// one pin: address compare, role select, polarity, registered output
module pcs_pin_strobe (
    input wire core_clk,
    input wire resetn,
    input wire [1:0] role,
    input wire [1:0] cmp_len,
    input wire active_high,
    input wire [15:0] base_addr,
    input wire [15:0] bus_addr,
    input wire bus_rd_n,
    input wire bus_wr_n,
    input wire io_bit,
    output reg pin_out_q,
    output reg pin_oe_n_q
);

    // ----------------------------------------
    // address window
    // ----------------------------------------
    reg [15:0] mask;
    reg hit;
    reg active;
    reg pin_d;

    // mask drops low address bits from the compare
    always @* begin
        case (cmp_len)
            `PCS_CMP_FULL: mask = 16'hffff;
            `PCS_CMP_A1: mask = 16'hfffe;
            `PCS_CMP_A2: mask = 16'hfffc;
            `PCS_CMP_A8: mask = 16'hff00;
            default: mask = 16'hffff;
        endcase
        hit = ((bus_addr & mask) == (base_addr & mask));
    end

    // strobe follows the matching access pulse, idle outside it
    always @* begin
        case (role)
            `PCS_ROLE_RD: active = hit & ~bus_rd_n;
            `PCS_ROLE_WR: active = hit & ~bus_wr_n;
            `PCS_ROLE_RW: active = hit & (~bus_rd_n | ~bus_wr_n);
            default: active = 1'b0;
        endcase
        if (role == `PCS_ROLE_IO) begin
            pin_d = io_bit;
        end else begin
            // inactive level is the complement of the active one
            pin_d = active ? active_high : ~active_high;
        end
    end

    // ----------------------------------------
    // output flops
    // ----------------------------------------
    // quasi-bidir: drive low hard, let a one float on the pull-up.
    // strobes are always driven since an idle strobe must hold level.
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            pin_out_q <= 1'b1;
            pin_oe_n_q <= 1'b1;
        end else begin
            pin_out_q <= pin_d;
            if (role == `PCS_ROLE_IO) begin
                pin_oe_n_q <= pin_d;
            end else begin
                pin_oe_n_q <= 1'b0;
            end
        end
    end

endmodule // pcs_pin_strobe

// ### hw/pcs_port_strobe.v
`timescale 1ns/100ps
`include "pcs_defines.vh"

// What this block does
// - top pin role from upper config bits 7,6
// - compare code 00 matches all 16 bits
// - codes 01/10/11 mask A0, A1-A0, A7-A0
// - range from own base pair plus length
// - third pin uses upper config bits 3..0
// - second pin uses lower config bits 7..4
// - first pin uses lower config bits 3..0
// - polarity bit 7: 1 high, 0 low
// - polarity bits 6,5,4 for pins 2,1,0
// - strobe follows read, write or either pulse
// - base address from high and low bytes
// - io mode outputs data nibble, quasi-bidirectional
module pcs_port_strobe (
    input wire core_clk,
    input wire resetn,
    input wire sfr_wr,
    input wire sfr_rd,
    input wire [7:0] sfr_addr,
    input wire [7:0] sfr_wdata,
    output reg [7:0] sfr_rdata_q,
    input wire [15:0] bus_addr,
    input wire bus_rd_n,
    input wire bus_wr_n,
    input wire [3:0] aux_pin_in,
    output wire [3:0] aux_pin_out,
    output wire [3:0] aux_pin_oe_n
);

    // ----------------------------------------
    // registers
    // ----------------------------------------
    reg [7:0] cfg_lo_q;
    reg [7:0] cfg_hi_q;
    reg [3:0] pol_q;
    reg [3:0] data_q;
    reg [7:0] base_lo_q [0:3];
    reg [7:0] base_hi_q [0:3];
    reg [3:0] pin_sync1_q;
    reg [3:0] pin_sync2_q;
    reg [7:0] rdata_d;
    integer i;
    integer ri;

    // base register address of pin n, hi selects the upper byte
    function [7:0] base_addr_of;
        input [1:0] pin;
        input hi;
        begin
            case (pin)
                2'd0: base_addr_of = hi ? `PCS_ADDR_B0_HI : `PCS_ADDR_B0_LO;
                2'd1: base_addr_of = hi ? `PCS_ADDR_B1_HI : `PCS_ADDR_B1_LO;
                2'd2: base_addr_of = hi ? `PCS_ADDR_B2_HI : `PCS_ADDR_B2_LO;
                default: base_addr_of = hi ? `PCS_ADDR_B3_HI : `PCS_ADDR_B3_LO;
            endcase
        end
    endfunction

    // byte writes from the core
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cfg_lo_q <= `PCS_RST_CFG;
            cfg_hi_q <= `PCS_RST_CFG;
            pol_q <= `PCS_RST_POL;
            data_q <= `PCS_RST_DATA;
            for (i = 0; i < 4; i = i + 1) begin
                base_lo_q[i] <= `PCS_RST_BASE;
                base_hi_q[i] <= `PCS_RST_BASE;
            end
        end else if (sfr_wr) begin
            if (sfr_addr == `PCS_ADDR_CFG_LO) begin
                cfg_lo_q <= sfr_wdata;
            end
            if (sfr_addr == `PCS_ADDR_CFG_HI) begin
                cfg_hi_q <= sfr_wdata;
            end
            if (sfr_addr == `PCS_ADDR_POL) begin
                pol_q <= sfr_wdata[7:4]; // low bits reserved, read as zero
            end
            if (sfr_addr == `PCS_ADDR_DATA) begin
                data_q <= sfr_wdata[3:0];
            end
            for (i = 0; i < 4; i = i + 1) begin
                if (sfr_addr == base_addr_of(i[1:0], 1'b0)) begin
                    base_lo_q[i] <= sfr_wdata;
                end
                if (sfr_addr == base_addr_of(i[1:0], 1'b1)) begin
                    base_hi_q[i] <= sfr_wdata;
                end
            end
        end
    end

    // pin readback crosses from the outside world
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            pin_sync1_q <= 4'hf;
            pin_sync2_q <= 4'hf;
        end else begin
            pin_sync1_q <= aux_pin_in;
            pin_sync2_q <= pin_sync1_q;
        end
    end

    // read mux; data address returns pin level like a standard port
    always @* begin
        rdata_d = 8'h00;
        if (sfr_addr == `PCS_ADDR_CFG_LO) begin
            rdata_d = cfg_lo_q;
        end
        if (sfr_addr == `PCS_ADDR_CFG_HI) begin
            rdata_d = cfg_hi_q;
        end
        if (sfr_addr == `PCS_ADDR_POL) begin
            rdata_d = {pol_q, `PCS_POL_RSVD};
        end
        if (sfr_addr == `PCS_ADDR_DATA) begin
            rdata_d = {4'h0, pin_sync2_q};
        end
        // own loop index, so the write process keeps sole ownership of i
        for (ri = 0; ri < 4; ri = ri + 1) begin
            if (sfr_addr == base_addr_of(ri[1:0], 1'b0)) begin
                rdata_d = base_lo_q[ri];
            end
            if (sfr_addr == base_addr_of(ri[1:0], 1'b1)) begin
                rdata_d = base_hi_q[ri];
            end
        end
    end

    // read data registered, held between reads
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            sfr_rdata_q <= 8'h00;
        end else if (sfr_rd) begin
            sfr_rdata_q <= rdata_d;
        end
    end

    // ----------------------------------------
    // per-pin strobe generators
    // ----------------------------------------
    // field slices: pin 3/2 from upper config, pin 1/0 from lower
    wire [1:0] role [0:3];
    wire [1:0] cmp [0:3];
    assign role[3] = cfg_hi_q[7:6];
    assign cmp[3] = cfg_hi_q[5:4];
    assign role[2] = cfg_hi_q[3:2];
    assign cmp[2] = cfg_hi_q[1:0];
    assign role[1] = cfg_lo_q[7:6];
    assign cmp[1] = cfg_lo_q[5:4];
    assign role[0] = cfg_lo_q[3:2];
    assign cmp[0] = cfg_lo_q[1:0];

    // bus_addr/rd/wr come from the core on this clock, no sync needed;
    // the strobe lags the core pulse by one cycle on both edges
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : pin_gen
            pcs_pin_strobe u_pin (
                .core_clk(core_clk),
                .resetn(resetn),
                .role(role[g]),
                .cmp_len(cmp[g]),
                .active_high(pol_q[g]),
                .base_addr({base_hi_q[g], base_lo_q[g]}),
                .bus_addr(bus_addr),
                .bus_rd_n(bus_rd_n),
                .bus_wr_n(bus_wr_n),
                .io_bit(data_q[g]),
                .pin_out_q(aux_pin_out[g]),
                .pin_oe_n_q(aux_pin_oe_n[g])
            );
        end
    endgenerate

endmodule // pcs_port_strobe

// ### tb/pcs_periph_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// peripheral side of the aux pins
// ----------------------------------------
module pcs_periph_model (
    input wire [3:0] pin_out,
    input wire [3:0] pin_oe_n,
    output wire [3:0] pin_lvl
);
    // a released pin is pulled up, a driven pin shows the drive value
    assign pin_lvl = pin_out | pin_oe_n;
endmodule  // pcs_periph_model

// ### tb/pcs_port_strobe_props.sv
`timescale 1ns/100ps
// ----------------------------------------
// pin0 checks against shadow registers
// ----------------------------------------
module pcs_port_strobe_props (
    input wire core_clk,
    input wire resetn,
    input wire sfr_wr,
    input wire sfr_rd,
    input wire [7:0] sfr_addr,
    input wire [7:0] sfr_wdata,
    input wire [7:0] sfr_rdata_q,
    input wire [15:0] bus_addr,
    input wire bus_rd_n,
    input wire bus_wr_n,
    input wire [3:0] aux_pin_in,
    input wire [3:0] aux_pin_out,
    input wire [3:0] aux_pin_oe_n
);
    reg [7:0] cl_q;
    reg pl_q;
    reg [15:0] b0_q;
    reg d0_q;
    wire [1:0] cm = cl_q[1:0];
    wire [15:0] m = cm == 2'b00 ? 16'hffff : cm == 2'b01 ? 16'hfffe :
        cm == 2'b10 ? 16'hfffc : 16'hff00;
    wire hit = ((bus_addr ^ b0_q) & m) == 16'h0000 &&
        ((cl_q[2] && !bus_rd_n) || (cl_q[3] && !bus_wr_n));
    wire strb = cl_q[3:2] != 2'b00;
    // shadow only what pin0 depends on, keeps the checker small
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cl_q <= 8'h00;
            pl_q <= 1'b0;
            b0_q <= 16'h0000;
            d0_q <= 1'b1;
        end else if (sfr_wr) begin
            if (sfr_addr == 8'hc2) cl_q <= sfr_wdata;
            if (sfr_addr == 8'hae) pl_q <= sfr_wdata[4];
            if (sfr_addr == 8'h84) b0_q[7:0] <= sfr_wdata;
            if (sfr_addr == 8'h85) b0_q[15:8] <= sfr_wdata;
            if (sfr_addr == 8'hd8) d0_q <= sfr_wdata[0];
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    a_strobe_active: assert property (strb && hit |=> aux_pin_out[0] == $past(pl_q))
        else $error("pin0 strobe not active");
    a_strobe_idle: assert property (strb && !hit |=> aux_pin_out[0] != $past(pl_q))
        else $error("pin0 strobe not idle");
    a_strobe_drives: assert property (strb |=> !aux_pin_oe_n[0])
        else $error("pin0 strobe not driven");
    a_io_quasi: assert property (!strb |=> aux_pin_oe_n[0] == aux_pin_out[0])
        else $error("pin0 io drive wrong");
    a_io_data: assert property (!strb |=> aux_pin_out[0] == $past(d0_q))
        else $error("pin0 io data wrong");
    a_cfg_readback: assert property (sfr_rd && sfr_addr == 8'hc2
        |=> sfr_rdata_q == $past(cl_q))
        else $error("config readback wrong");
    a_base_readback: assert property (sfr_rd && sfr_addr == 8'h85
        |=> sfr_rdata_q == $past(b0_q[15:8]))
        else $error("base readback wrong");
    a_pol_reserved: assert property (sfr_rd && sfr_addr == 8'hae
        |=> sfr_rdata_q[3:0] == 4'h0)
        else $error("reserved bits not zero");
    a_rdata_holds: assert property (!sfr_rd |=> $stable(sfr_rdata_q))
        else $error("read data moved");
endmodule  // pcs_port_strobe_props

bind pcs_port_strobe pcs_port_strobe_props u_props (.core_clk(core_clk), .resetn(resetn),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_rdata_q(sfr_rdata_q), .bus_addr(bus_addr), .bus_rd_n(bus_rd_n), .bus_wr_n(bus_wr_n),
    .aux_pin_in(aux_pin_in), .aux_pin_out(aux_pin_out), .aux_pin_oe_n(aux_pin_oe_n));

// ### tb/tb_top.sv
`timescale 1ns/100ps
// ----------------------------------------
// register and strobe regression
// ----------------------------------------
module tb_top;
    logic core_clk, resetn, sfr_wr, sfr_rd, bus_rd_n, bus_wr_n, pol, h;
    logic [7:0] sfr_addr, sfr_wdata, v;
    logic [15:0] bus_addr, a;
    logic [1:0] role;
    wire [7:0] sfr_rdata_q;
    wire [3:0] aux_pin_out, aux_pin_oe_n, aux_pin_in;
    int n_fail, cmp_count, p, k, j, r;
    logic [15:0] msk [4] = '{16'hffff, 16'hfffe, 16'hfffc, 16'hff00};
    logic [15:0] offs [5] = '{16'h0000, 16'h0001, 16'h0002, 16'h0080, 16'h0100};
    logic [7:0] ba [4] = '{8'h84, 8'h94, 8'hac, 8'hb4};
    pcs_port_strobe u_dut (.core_clk(core_clk), .resetn(resetn), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata_q(sfr_rdata_q),
        .bus_addr(bus_addr), .bus_rd_n(bus_rd_n), .bus_wr_n(bus_wr_n), .aux_pin_in(aux_pin_in),
        .aux_pin_out(aux_pin_out), .aux_pin_oe_n(aux_pin_oe_n));
    pcs_periph_model u_periph (.pin_out(aux_pin_out), .pin_oe_n(aux_pin_oe_n),
        .pin_lvl(aux_pin_in));
    // 50 MHz clock
    initial begin
        core_clk = 0;
        forever #10 core_clk = ~core_clk;
    end
    task chk(input [15:0] seen, input [15:0] exp, input string nm);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task wr(input [7:0] ad, input [7:0] d);
        @(posedge core_clk);
        #1;
        sfr_wr = 1;
        sfr_addr = ad;
        sfr_wdata = d;
        @(posedge core_clk);
        #1;
        sfr_wr = 0;
    endtask
    task rd(input [7:0] ad);
        @(posedge core_clk);
        #1;
        sfr_rd = 1;
        sfr_addr = ad;
        @(posedge core_clk);
        #1;
        v = sfr_rdata_q;
        sfr_rd = 0;
    endtask
    // one bus access on pin p, then the pulse ends and the strobe must idle
    task acc(input [15:0] ad, input int rdop, input int pin, input hit);
        @(posedge core_clk);
        #1;
        bus_addr = ad;
        bus_rd_n = !rdop;
        bus_wr_n = rdop;
        @(posedge core_clk);
        #1;
        chk(aux_pin_out[pin], hit ? pol : !pol, "strobe");
        bus_rd_n = 1;
        bus_wr_n = 1;
        @(posedge core_clk);
        #1;
        chk(aux_pin_out[pin], !pol, "idle");
    endtask
    task end_sim;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // hang guard
    initial begin
        #500000;
        n_fail++;
        end_sim;
    end
    initial begin
        {resetn, sfr_wr, sfr_rd, sfr_addr, sfr_wdata, bus_addr} = 0;
        {bus_rd_n, bus_wr_n} = 2'b11;
        repeat (16) @(posedge core_clk);
        #1;
        resetn = 1;
        chk(aux_pin_out, 4'hf, "reset pins");
        rd(8'hc3);
        chk(v, 8'h00, "cfg reset");
        wr(8'hae, 8'hff);
        rd(8'hae);
        chk(v, 8'hf0, "polarity");
        wr(8'h00, 8'h55);
        rd(8'h00);
        chk(v, 8'h00, "unmapped");
        $display("test registers done");
        wr(8'hae, 8'h00);
        wr(8'hd8, 8'h0a);
        // the pin flop takes the new data one edge after the write lands
        @(posedge core_clk);
        #1;
        chk(aux_pin_out, 4'ha, "io out");
        chk(aux_pin_oe_n, 4'ha, "io oe");
        repeat (3) @(posedge core_clk);
        rd(8'hd8);
        chk(v[3:0], 4'ha, "io level");
        $display("test io done");
        // every pin through every strobe role and compare length
        for (p = 0; p < 4; p++) begin
            for (k = 0; k < 4; k++) begin
                role = k % 3 + 1;
                pol = k[0];
                wr(p[1] ? 8'hc3 : 8'hc2, {4'h0, role, k[1:0]} << (p[0] * 4));
                wr(ba[p], 8'hc4);
                wr(ba[p] + 8'h01, 8'h12);
                wr(8'hae, {7'h00, pol} << (4 + p));
                rd(ba[p] + 8'h01);
                chk(v, 8'h12, "base hi");
                chk(aux_pin_oe_n[p], 1'b0, "strobe oe");
                for (j = 0; j < 5; j++) begin
                    a = 16'h12c4 ^ offs[j];
                    h = ((a ^ 16'h12c4) & msk[k]) == 16'h0000;
                    for (r = 0; r < 2; r++)
                        acc(a, r, p, h && role[r ? 0 : 1]);
                end
            end
        end
        $display("test strobes done");
        end_sim;
    end
endmodule  // tb_top
